/* verilog/gpb_port_bank.sv */
// How it works
// - Forty-two pins in six ports; the last port has two pins.
// - Each pin has its own direction bit, writable any time.
// - Direction one makes an input read live; zero makes it drive.
// - Inputs are not latched; a read samples the pin then.
// - Written output data holds until the data register is rewritten.
// - Reading an output pin returns the latch, not the pin.
// - Reset sets all data and direction bits to one.
// - Bit set or clear reads the port, modifies, writes it back.
// - In power-down a falling edge on a wake pin wakes the device.
// - Wake select is per pin on ports A and B, per nibble on C to E, one bit for both F pins.
// - Pull-high only connects while the pin is an input.
// - Port A outputs are push-pull, pull-down-only or pull-up-only.
// - Four port B pins carry serial signals when serial is on.
`timescale 1ns/10ps
`default_nettype none
module gpb_port_bank
(
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire gpb_pkg::gpb_req_t             req,
    output logic      [7:0]                    rdata,
    input  wire logic [gpb_pkg::PIN_COUNT-1:0] pin_in,
    output logic      [gpb_pkg::PIN_COUNT-1:0] pin_out,
    output logic      [gpb_pkg::PIN_COUNT-1:0] pin_oe_n,
    output logic      [gpb_pkg::PIN_COUNT-1:0] pull_high_en,
    input  wire logic [gpb_pkg::PIN_COUNT-1:0] pull_high_opt,
    input  wire logic [15:0]                   port_a_out_type,
    input  wire gpb_pkg::gpb_sif_t             serial_if_control_zero,
    output logic      [3:0]                    sif_in,
    input  wire logic [gpb_pkg::WAKE_BIT_W-1:0] wake_pin_sel,
    input  wire logic [gpb_pkg::NIB_COUNT-1:0] wake_nib_sel,
    input  wire logic                          wake_f_sel,
    input  wire logic                          power_down,
    output logic                               wake_up
);
    logic [7:0]                    data_reg [gpb_pkg::NUM_PORTS];
    logic [7:0]                    dir_reg  [gpb_pkg::NUM_PORTS];
    logic [7:0]                    rdata_reg;
    logic [gpb_pkg::PIN_COUNT-1:0] armed_reg;
    logic [gpb_pkg::PIN_COUNT-1:0] pin_level;
    logic [gpb_pkg::PIN_COUNT-1:0] data_flat;
    logic [gpb_pkg::PIN_COUNT-1:0] dir_flat;
    logic [gpb_pkg::PIN_COUNT-1:0] wake_sel;
    logic [7:0]                    live     [gpb_pkg::NUM_PORTS];
    logic [7:0]                    rd_value;
    logic [7:0]                    rmw_base;
    logic [7:0]                    wr_value;

    // Unused port codes read as zero: the mask clears what the out-of-range array index returns
    function automatic logic [7:0] port_mask(input logic [2:0] p);
        if (p == gpb_pkg::PORT_F)
            return gpb_pkg::MASK_PORT_F;
        else if (p > gpb_pkg::PORT_F)
            return 8'h00;
        else
            return gpb_pkg::MASK_FULL;
    endfunction

    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] b,
                                           input logic s);
        logic [7:0] r;
        r    = v;
        r[b] = s;
        return r;
    endfunction

    gpb_pin_sync u_sync
    (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .pin_raw   (pin_in),
        .pin_level (pin_level)
    );

    // Pins map as port*8+bit; port F stops after two bits
    always_comb
    begin
        for (int p = 0; p < gpb_pkg::NUM_PORTS; p++)
            live[p] = '0;
        for (int i = 0; i < gpb_pkg::PIN_COUNT; i++)
        begin
            live[i/8][i%8] = pin_level[i];
            data_flat[i]   = data_reg[i/8][i%8];
            dir_flat[i]    = dir_reg[i/8][i%8];
        end
    end

    // Input bits show the synchronised pin, output bits the latch
    always_comb
    begin
        rd_value = ((dir_reg[req.port] & live[req.port])
                 | (~dir_reg[req.port] & data_reg[req.port]))
                 & port_mask(req.port);
        if (req.sel_dir)
            rd_value = dir_reg[req.port] & port_mask(req.port);
    end

    // A bit operation on the data register writes back input-pin levels too
    always_comb
    begin
        rmw_base = rd_value;
        if (req.bit_op)
            wr_value = set_bit(rmw_base, req.bit_idx, req.bit_set) & port_mask(req.port);
        else
            wr_value = req.wdata & port_mask(req.port);
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            for (int p = 0; p < gpb_pkg::NUM_PORTS; p++)
            begin
                data_reg[p] <= gpb_pkg::RESET_DATA & port_mask(3'(p));
                dir_reg[p]  <= gpb_pkg::RESET_DIR & port_mask(3'(p));
            end
        end
        else if (req.wr && req.port < 3'(gpb_pkg::NUM_PORTS))
        begin
            if (req.sel_dir)
                dir_reg[req.port] <= wr_value;
            else
                data_reg[req.port] <= wr_value;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdata_reg <= '0;
        else if (req.rd)
            rdata_reg <= rd_value;
    end

    assign rdata = rdata_reg;

    // Pin drivers, output-type options and serial sharing
    always_comb
    begin
        pin_out      = data_flat;
        pin_oe_n     = dir_flat;
        pull_high_en = pull_high_opt & dir_flat;
        for (int i = 0; i < 8; i++)
        begin
            if (port_a_out_type[2*i +: 2] == gpb_pkg::OUT_PULL_DOWN)
            begin
                pin_out[i]  = 1'b0;
                pin_oe_n[i] = dir_flat[i] | data_flat[i];
            end
            else if (port_a_out_type[2*i +: 2] == gpb_pkg::OUT_PULL_UP)
            begin
                pin_out[i]  = 1'b1;
                pin_oe_n[i] = dir_flat[i] | ~data_flat[i];
            end
        end
        if (serial_if_control_zero.en)
        begin
            pin_out[gpb_pkg::SIF_LO +: gpb_pkg::SIF_W]  = serial_if_control_zero.out;
            pin_oe_n[gpb_pkg::SIF_LO +: gpb_pkg::SIF_W] = serial_if_control_zero.drive_n;
        end
    end

    assign sif_in = pin_level[gpb_pkg::SIF_LO +: gpb_pkg::SIF_W];

    // Ports A and B per pin, C to E per nibble, F as one group
    always_comb
    begin
        wake_sel = '0;
        wake_sel[gpb_pkg::WAKE_BIT_W-1:0] = wake_pin_sel;
        for (int i = gpb_pkg::WAKE_BIT_W; i < 40; i++)
            wake_sel[i] = wake_nib_sel[(i - gpb_pkg::WAKE_BIT_W) / 4];
        wake_sel[40] = wake_f_sel;
        wake_sel[41] = wake_f_sel;
    end

    // Arm only pins seen high before the clock stops, so a later low is a falling edge
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            armed_reg <= '0;
        else if (!power_down)
            armed_reg <= wake_sel & pin_level;
    end

    // Combinational so it works with the system clock stopped
    assign wake_up = power_down & |(armed_reg & ~pin_in);

    sequence s_write_data;
        req.wr && !req.sel_dir && !req.bit_op && req.port == gpb_pkg::PORT_A;
    endsequence

    a_reset_all_ones: assert property (@(posedge ref_clk)
        sys_rst |=> dir_flat == '1 && data_flat == '1)
        else $error("Reset did not set data and direction high");

    a_dir_bit_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req.wr && req.sel_dir && !req.bit_op && req.port == gpb_pkg::PORT_C
        |=> dir_reg[2] == $past(req.wdata))
        else $error("Direction write not stored");

    a_data_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(req.wr && !req.sel_dir && req.port == gpb_pkg::PORT_A) |=> $stable(data_reg[0]))
        else $error("Port A latch changed without a write");

    a_write_then_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_write_data ##1 !req.wr [*2] |-> data_reg[0] == $past(req.wdata, 2))
        else $error("Written port A data not held");

    a_output_read_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req.rd && !req.sel_dir && dir_reg[req.port] == 8'h00
        |=> rdata == $past(data_reg[req.port] & port_mask(req.port)))
        else $error("Output read did not return latch");

    a_input_read_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req.rd && !req.sel_dir && req.port == gpb_pkg::PORT_D && dir_reg[3] == 8'hff
        |=> rdata == $past(pin_level[31:24]))
        else $error("Input read did not sample pin");

    a_bit_rmw: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req.wr && req.bit_op && req.sel_dir && req.port == gpb_pkg::PORT_B
        |=> dir_reg[1] == set_bit($past(dir_reg[1]), $past(req.bit_idx), $past(req.bit_set)))
        else $error("Bit operation changed other bits");

    a_pull_only_input: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (pull_high_en & ~dir_flat) == '0)
        else $error("Pull-high on an output pin");

    a_wake_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !power_down |=> (armed_reg & ~$past(wake_sel)) == '0)
        else $error("Wake from an unselected pin");

    a_port_f_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (data_reg[5] & ~gpb_pkg::MASK_PORT_F) == 8'h00)
        else $error("Port F grew beyond two pins");
endmodule
`default_nettype wire

/* verilog/gpb_pkg.sv */
`default_nettype none
package gpb_pkg;
    localparam int          NUM_PORTS   = 6;
    localparam int          PORT_W      = 8;
    localparam int          PIN_COUNT   = 42;
    localparam int          NIB_COUNT   = 6;
    localparam logic [2:0]  PORT_A      = 3'h0;
    localparam logic [2:0]  PORT_B      = 3'h1;
    localparam logic [2:0]  PORT_C      = 3'h2;
    localparam logic [2:0]  PORT_D      = 3'h3;
    localparam logic [2:0]  PORT_E      = 3'h4;
    localparam logic [2:0]  PORT_F      = 3'h5;
    localparam logic [7:0]  MASK_FULL   = 8'hff;
    localparam logic [7:0]  MASK_PORT_F = 8'h03;
    localparam logic [7:0]  RESET_DATA  = 8'hff;
    localparam logic [7:0]  RESET_DIR   = 8'hff;
    localparam int          SIF_LO      = 8;
    localparam int          SIF_W       = 4;
    localparam int          WAKE_BIT_W  = 16;
    localparam logic [1:0]  OUT_PUSH_PULL = 2'h0;
    localparam logic [1:0]  OUT_PULL_DOWN = 2'h1;
    localparam logic [1:0]  OUT_PULL_UP   = 2'h2;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bit_op;
        logic       bit_set;
        logic       sel_dir;
        logic [2:0] port;
        logic [2:0] bit_idx;
        logic [7:0] wdata;
    } gpb_req_t;

    typedef struct packed {
        logic       en;
        logic [3:0] out;
        logic [3:0] drive_n;
    } gpb_sif_t;
endpackage
`default_nettype wire

/* verilog/gpb_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module gpb_pin_sync
(
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire logic [gpb_pkg::PIN_COUNT-1:0] pin_raw,
    output logic      [gpb_pkg::PIN_COUNT-1:0] pin_level
);
    logic [gpb_pkg::PIN_COUNT-1:0] s1_reg;
    logic [gpb_pkg::PIN_COUNT-1:0] s2_reg;
    logic [gpb_pkg::PIN_COUNT-1:0] s3_reg;
    logic [gpb_pkg::PIN_COUNT-1:0] level_reg;

    always_ff @(posedge ref_clk)
    begin
        s1_reg <= pin_raw;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // Only bits where stages two and three agree are taken, filtering one-cycle glitches
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            level_reg <= '1;
        else
            level_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (level_reg & (s2_reg ^ s3_reg));
    end

    assign pin_level = level_reg;
endmodule
`default_nettype wire

/* sim/gpb_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module gpb_board_model
(
    input  wire logic        ref_clk,
    input  wire logic [41:0] pin_out,
    input  wire logic [41:0] pin_oe_n,
    input  wire logic [41:0] pull_high_en,
    input  wire logic [41:0] ext_level,
    input  wire logic [41:0] ext_drive,
    output logic      [41:0] pin_in
);
    // Floating pins toggle so a stale level never passes for a real one
    logic [41:0] float_pat = 42'h0;
    always @(posedge ref_clk)
        float_pat <= ~float_pat;
    always_comb
    begin
        for (int i = 0; i < 42; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_drive[i])
                pin_in[i] = ext_level[i];
            else if (pull_high_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_pat[i];
        end
    end
endmodule
`default_nettype wire

/* sim/test_bidirectional_port_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module test_bidirectional_port_bank;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    gpb_pkg::gpb_req_t req = '0;
    gpb_pkg::gpb_sif_t sif_ctl = '0;
    logic [7:0]  rdata, v, d, dr, e;
    logic [41:0] pin_in, pin_out, pin_oe_n, pull_high_en;
    logic [41:0] pull_high_opt = '0, ext_level = '1, ext_drive = '1;
    logic [15:0] wake_pin_sel = '0, out_type = '0;
    logic [5:0]  wake_nib_sel = '0;
    logic        wake_f_sel = 1'b0, power_down = 1'b0, wake_up;
    logic [3:0]  sif_in;
    int          failures = 0, checked = 0, p, b;
    initial forever #4 ref_clk = ~ref_clk;
    gpb_port_bank uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_high_en(pull_high_en),
        .pull_high_opt(pull_high_opt), .port_a_out_type(out_type),
        .serial_if_control_zero(sif_ctl), .sif_in(sif_in), .wake_pin_sel(wake_pin_sel),
        .wake_nib_sel(wake_nib_sel), .wake_f_sel(wake_f_sel), .power_down(power_down),
        .wake_up(wake_up));
    gpb_board_model board (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pull_high_en(pull_high_en), .ext_level(ext_level), .ext_drive(ext_drive),
        .pin_in(pin_in));
    function automatic logic [7:0] pslice(input logic [41:0] x, input int n);
        if (n == 5)
            return {6'h00, x[41:40]};
        return x[n*8 +: 8];
    endfunction
    // Returns {active-low pin enables, pin values} of port A with every pin set as output
    function automatic logic [15:0] drive_exp(input logic [15:0] t, input logic [7:0] dv);
        logic [15:0] r;
        r = {8'h00, dv};
        for (int i = 0; i < 8; i++)
        begin
            if (t[2*i +: 2] == gpb_pkg::OUT_PULL_DOWN)
            begin
                r[i]     = 1'b0;
                r[8 + i] = dv[i];
            end
            else if (t[2*i +: 2] == gpb_pkg::OUT_PULL_UP)
            begin
                r[i]     = 1'b1;
                r[8 + i] = ~dv[i];
            end
        end
        return r;
    endfunction
    function automatic logic [7:0] pmask(input int n);
        return (n == 5) ? gpb_pkg::MASK_PORT_F : gpb_pkg::MASK_FULL;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input logic w, r, bo, bs, sd, input int n, bi, input logic [7:0] wd);
        @(posedge ref_clk);
        req <= '{wr:w, rd:r, bit_op:bo, bit_set:bs, sel_dir:sd, port:3'(n), bit_idx:3'(bi),
                 wdata:wd};
        @(posedge ref_clk);
        req <= '0;
    endtask
    task automatic rd_port(input logic sd, input int n, output logic [7:0] val);
        send(1'b0, 1'b1, 1'b0, 1'b0, sd, n, 0, 8'h00);
        @(posedge ref_clk);
        #1 val = rdata;
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wake_try(input int fall_pin, input logic exp);
        ext_level <= '1;
        repeat (6) @(posedge ref_clk);
        power_down <= 1'b1;
        @(posedge ref_clk);
        ext_level[fall_pin] <= 1'b0;
        // No clock edge between the fall and the look: wake must not need the clock
        #1 check("wake_up", {7'h00, wake_up}, {7'h00, exp});
        power_down <= 1'b0;
    endtask
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(51443));
        pull_high_opt = {10'($urandom), $urandom};
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (p = 0; p < 6; p++)
        begin
            rd_port(1'b0, p, v);
            check("data reset", v, pmask(p));
            rd_port(1'b1, p, v);
            check("dir reset", v, pmask(p));
            check("oe_n reset", pslice(pin_oe_n, p), pmask(p));
            check("out reset", pslice(pin_out, p), pmask(p));
        end
        $display("test reset done");
        for (int k = 0; k < 36; k++)
        begin
            p = k % 6;
            d = 8'($urandom);
            dr = 8'($urandom);
            // Shared serial pins serve as plain I/O here
            ext_level <= {10'($urandom), $urandom};
            // Data last, so a port A write is followed by idle cycles
            send(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, p, 0, dr);
            send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, p, 0, d);
            repeat (5) @(posedge ref_clk);
            rd_port(1'b0, p, v);
            e = ((dr & pslice(ext_level, p)) | (~dr & d)) & pmask(p);
            check("port read", v, e);
            check("pin drive", pslice(pin_out, p) & ~dr & pmask(p), d & ~dr & pmask(p));
            check("oe_n", pslice(pin_oe_n, p), dr & pmask(p));
            check("pull high", pslice(pull_high_en, p), pslice(pull_high_opt, p) & dr & pmask(p));
        end
        $display("test random access done");
        for (int k = 0; k < 12; k++)
        begin
            p = k % 6;
            send(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, p, 0, 8'h00);
            rd_port(1'b0, p, e);
            rd_port(1'b1, p, dr);
            for (b = 0; b < ((p == 5) ? 2 : 8); b++)
            begin
                v[0] = 1'($urandom);
                e[b] = v[0];
                send(1'b1, 1'b0, 1'b1, v[0], 1'b0, p, b, 8'h00);
                v[1] = 1'($urandom);
                dr[b] = v[1];
                send(1'b1, 1'b0, 1'b1, v[1], 1'b1, p, b, 8'h00);
                send(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, p, b, 8'h00);
                dr[b] = 1'b0;
            end
            rd_port(1'b0, p, v);
            check("bit op data", v, e);
            rd_port(1'b1, p, v);
            check("bit op dir", v, dr);
        end
        $display("test bit ops done");
        sys_rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wake_pin_sel <= 16'h0001;
        wake_try(1, 1'b0);
        wake_try(0, 1'b1);
        wake_nib_sel <= 6'h01;
        wake_try(17, 1'b1);
        wake_nib_sel <= 6'h00;
        wake_try(17, 1'b0);
        $display("test wake done");
        send(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 0, 0, 8'h00);
        d = 8'($urandom);
        send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 0, 0, d);
        out_type <= 16'($urandom);
        sif_ctl <= '{en:1'b1, out:4'($urandom), drive_n:4'($urandom)};
        repeat (6) @(posedge ref_clk);
        #1 {e, v} = drive_exp(out_type, d);
        check("type out", pslice(pin_out, 0), v);
        check("type oe_n", pslice(pin_oe_n, 0), e);
        check("sif out", {4'h0, pin_out[11:8]}, {4'h0, sif_ctl.out});
        check("sif oe_n", {4'h0, pin_oe_n[11:8]}, {4'h0, sif_ctl.drive_n});
        dr = {4'h0, (sif_ctl.drive_n & ext_level[11:8]) | (~sif_ctl.drive_n & sif_ctl.out)};
        check("sif in", {4'h0, sif_in}, dr);
        $display("test pin sharing done");
        print_verdict();
    end
endmodule
`default_nettype wire
